// >>> design/ebtc_pkg.sv
package ebtc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  OFS_COUNT    = 5'h00;
    localparam logic [4:0]  OFS_CTRL     = 5'h04;
    localparam logic [4:0]  OFS_STATUS   = 5'h08;
    localparam logic [4:0]  OFS_CLEAR    = 5'h0c;
    localparam logic [4:0]  OFS_ENABLE   = 5'h10;

    // ------------------------------------------------------------
    // control register fields, flag bit and count limits
    // ------------------------------------------------------------
    localparam int          CTRL_W       = 6;
    localparam int          BIT_CSS      = 5;
    localparam int          BIT_SES      = 4;
    localparam int          BIT_BYP      = 3;
    localparam int          RATE_MSB     = 2;
    localparam logic [5:0]  CTRL_RST     = 6'h3f;
    localparam int          BIT_OVF      = 0;
    localparam logic [7:0]  COUNT_RST    = 8'h00;
    localparam logic [7:0]  COUNT_MAX    = 8'hff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_NS       = 10;
    localparam int          INSTR_NS     = 40;
    localparam int          INSTR_CLKS   = INSTR_NS / CLK_NS;
    localparam logic [1:0]  PH_Q2        = 2'(1);
    localparam logic [1:0]  PH_Q4        = 2'(INSTR_CLKS - 1);
    localparam logic [1:0]  HOLD_INSTR   = 2'h2;
endpackage : ebtc_pkg

// >>> design/ebtc_timer.sv
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - eight-bit count register, used as timer or as event counter
// - timer mode without prescaler adds one every instruction cycle
// - source select cleared picks timer mode on instruction cycles
// - no increment for two instruction cycles after a count write
// - source select set counts external pin transitions instead
// - edge select picks rising or falling pin transitions
// - bypass cleared routes events through the private prescaler
// - three-bit rate gives eight ratios, 1:2 up to 1:256
// - 1:1 only with prescaler bypassed, each event counts directly
// - prescaler count is neither readable nor writable
// - every count write clears the prescaler
// - overflow event output serves as gate for sixteen-bit timer
// - wrap from maximum to zero sets the overflow flag
// - flag sets regardless of enable; only a clear write or reset clears it
// - counter mode prescaler output sampled on Q2 and Q4
// - sleep freezes counting and keeps the count unchanged
module ebtc_timer
    import ebtc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic [31:0]            readdata,
    output logic                   waitrequest,
    input  wire logic              externalCountPin,
    input  wire logic              sleepMode,
    output logic                   overflowEvent,
    output logic                   irq
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic              wait_ff;
    logic [31:0]       rdata_ff;
    logic [7:0]        count_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic              flag_ff;
    logic              ien_ff;

    wire req       = read | write;
    wire accept    = req & ~wait_ff;
    wire lane0     = byteenable[0];
    wire wrCount   = accept & write & lane0 & (address == OFS_COUNT);
    wire wrCtrl    = accept & write & lane0 & (address == OFS_CTRL);
    wire wrClear   = accept & write & lane0 & (address == OFS_CLEAR);
    wire wrEnable  = accept & write & lane0 & (address == OFS_ENABLE);
    wire [7:0] wd  = writedata[7:0];

    // prescaler has no read path at all
    wire [7:0] rdSel = (address == OFS_COUNT)  ? count_ff :
                       (address == OFS_CTRL)   ? {2'h0, ctrl_ff} :
                       (address == OFS_STATUS) ? {7'h0, flag_ff} :
                       (address == OFS_ENABLE) ? {7'h0, ien_ff} :
                       8'h00;

    // one wait cycle; data is ready at the edge it is sampled
    wire        nxt_wait  = ~(req & wait_ff);
    wire [31:0] nxt_rdata = (req & wait_ff) ? {24'h0, rdSel} : rdata_ff;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    assign waitrequest = wait_ff;
    assign readdata    = rdata_ff;

    // ------------------------------------------------------------
    // instruction clock phases
    // ------------------------------------------------------------
    logic [1:0] phase_ff;
    wire q4En     = (phase_ff == PH_Q4);
    wire q2En     = (phase_ff == PH_Q2);
    wire sampleEn = q2En | q4En;
    wire active   = ~sleepMode;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            phase_ff <= 2'h0;
        else
            phase_ff <= phase_ff + 2'h1;
    end

    // ------------------------------------------------------------
    // source selection and prescaler
    // ------------------------------------------------------------
    logic       pinPrev_ff;
    logic [7:0] psc_ff;
    logic       pend_ff;
    logic [1:0] hold_ff;

    // settings are read live, so a change acts on the next event
    wire       css    = ctrl_ff[BIT_CSS];
    wire       ses    = ctrl_ff[BIT_SES];
    wire       bypass = ctrl_ff[BIT_BYP];
    wire [2:0] rate   = ctrl_ff[RATE_MSB:0];

    wire pinRise  = ~pinPrev_ff & externalCountPin;
    wire pinFall  = pinPrev_ff & ~externalCountPin;
    wire pinEdge  = ses ? pinFall : pinRise;
    wire srcEvent = css ? pinEdge : q4En;

    wire [8:0] maskW   = (9'h002 << rate) - 9'h001;
    wire [7:0] pscMask = maskW[7:0];
    wire       pscFull = (psc_ff & pscMask) == pscMask;
    wire       pscOut  = bypass ? srcEvent : (srcEvent & pscFull);
    wire       pscStep = srcEvent & active & ~bypass;

    wire [7:0] nxt_psc = wrCount ? 8'h00 :
                         pscStep ? psc_ff + 8'h01 : psc_ff;

    // pin events wait for the next Q2 or Q4 sample point
    wire nxt_pend = wrCount ? 1'b0 :
                    (pscOut & css & active) ? 1'b1 :
                    sampleEn ? 1'b0 : pend_ff;

    wire tick = css ? (pend_ff & sampleEn) : pscOut;

    // counting held off over the next two instruction boundaries
    wire [1:0] nxt_hold = wrCount ? HOLD_INSTR :
                          (q4En & (hold_ff != 2'h0)) ? hold_ff - 2'h1 :
                          hold_ff;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pinPrev_ff <= 1'b0;
            psc_ff     <= 8'h00;
            pend_ff    <= 1'b0;
            hold_ff    <= 2'h0;
        end else begin
            pinPrev_ff <= externalCountPin;
            psc_ff     <= nxt_psc;
            pend_ff    <= nxt_pend;
            hold_ff    <= nxt_hold;
        end
    end

    // ------------------------------------------------------------
    // count register and overflow
    // ------------------------------------------------------------
    logic gate_ff;
    logic irq_ff;

    wire incEn = tick & active & (hold_ff == 2'h0) & ~wrCount;
    wire ovf   = incEn & (count_ff == COUNT_MAX);

    wire [7:0] nxt_count = wrCount ? wd :
                           incEn ? count_ff + 8'h01 : count_ff;

    // a wrap in the clearing cycle still leaves the flag set
    wire clrHit   = wrClear & wd[BIT_OVF];
    wire nxt_flag = ovf | (flag_ff & ~clrHit);

    wire [CTRL_W-1:0] nxt_ctrl = wrCtrl ? wd[CTRL_W-1:0] : ctrl_ff;
    wire              nxt_ien  = wrEnable ? wd[BIT_OVF] : ien_ff;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_ff <= COUNT_RST;
            ctrl_ff  <= CTRL_RST;
            flag_ff  <= 1'b0;
            ien_ff   <= 1'b0;
            gate_ff  <= 1'b0;
            irq_ff   <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            ctrl_ff  <= nxt_ctrl;
            flag_ff  <= nxt_flag;
            ien_ff   <= nxt_ien;
            gate_ff  <= ovf;
            irq_ff   <= flag_ff & ien_ff;
        end
    end

    assign overflowEvent = gate_ff;
    assign irq           = irq_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    bus_answer_a: assert property (req && wait_ff |=> !wait_ff)
        else $error("bus request not answered after one wait");

    hold_off_a: assert property (wrCount |=> !incEn [*5])
        else $error("count advanced during write hold-off");

    sleep_freeze_a: assert property (
        sleepMode && !wrCount |=> count_ff == $past(count_ff))
        else $error("count changed while asleep");

    ovf_set_a: assert property (
        incEn && count_ff == COUNT_MAX |=> flag_ff && count_ff == 8'h00)
        else $error("wrap did not set overflow flag");

    flag_keep_a: assert property (
        flag_ff && !clrHit |=> flag_ff)
        else $error("overflow flag lost without clear");

    psc_clear_a: assert property (wrCount |=> psc_ff == 8'h00)
        else $error("prescaler not cleared by count write");

    timer_step_a: assert property (
        !css && bypass && active && q4En && hold_ff == 2'h0 && !wrCount
        |=> count_ff == $past(count_ff) + 8'h01)
        else $error("timer mode missed an instruction cycle");

    direct_pend_a: assert property (
        css && bypass && active && pinEdge && !wrCount |=> pend_ff)
        else $error("bypassed pin edge not captured");

    gate_pulse_a: assert property (
        ovf |=> overflowEvent ##1 !overflowEvent || $past(ovf, 1))
        else $error("overflow event output not driven");

    irq_level_a: assert property (flag_ff && ien_ff |=> irq)
        else $error("interrupt not raised for enabled flag");

    // ------------------------------------------------------------
    // phase, bus, register, flag, source, prescaler, hold-off, sleep and output checks
    // ------------------------------------------------------------
    phase_step_a: assert property (
        1'b1 |=> phase_ff == $past(phase_ff) + 2'h1)
        else $error("instruction phase counter skipped");

    wait_once_a: assert property (
        !wait_ff |=> wait_ff)
        else $error("waitrequest low for more than one cycle");

    idle_wait_a: assert property (
        !req |=> wait_ff)
        else $error("waitrequest low without a request");

    rdata_upper_a: assert property (
        readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");

    rd_count_a: assert property (
        req && wait_ff && address == OFS_COUNT |=> readdata == {24'h0, $past(count_ff)})
        else $error("count read returned wrong value");

    rd_status_a: assert property (
        req && wait_ff && address == OFS_STATUS |=> readdata == {31'h0, $past(flag_ff)})
        else $error("status read returned wrong value");

    rd_clear_a: assert property (
        req && wait_ff && address == OFS_CLEAR |=> readdata == 32'h0)
        else $error("clear register read not zero");

    count_load_a: assert property (
        wrCount |=> count_ff == $past(wd))
        else $error("count write did not land");

    ctrl_load_a: assert property (
        wrCtrl |=> ctrl_ff == $past(wd[CTRL_W-1:0]))
        else $error("control write did not land");

    ien_load_a: assert property (
        wrEnable |=> ien_ff == $past(wd[BIT_OVF]))
        else $error("enable write did not land");

    ctrl_keep_a: assert property (
        !wrCtrl |=> $stable(ctrl_ff))
        else $error("control changed without a write");

    count_keep_a: assert property (
        wrCtrl && !incEn |=> count_ff == $past(count_ff))
        else $error("control write disturbed the count");

    flag_clear_a: assert property (
        clrHit && !ovf |=> !flag_ff)
        else $error("overflow flag not cleared by write");

    flag_source_a: assert property (
        !flag_ff && !ovf |=> !flag_ff)
        else $error("overflow flag set without a wrap");

    timer_src_a: assert property (
        !css |-> srcEvent == q4En)
        else $error("timer mode not on instruction cycles");

    pin_src_a: assert property (
        css |-> srcEvent == pinEdge)
        else $error("counter mode not on pin edges");

    edge_rise_a: assert property (
        css && !ses && pinRise |-> srcEvent)
        else $error("rising pin edge not taken");

    edge_fall_a: assert property (
        css && ses && pinFall |-> srcEvent)
        else $error("falling pin edge not taken");

    edge_wrong_a: assert property (
        css && !ses && pinFall |-> !srcEvent)
        else $error("unselected pin edge taken");

    psc_step_a: assert property (
        pscStep && !wrCount |=> psc_ff == $past(psc_ff) + 8'h01)
        else $error("prescaler missed a source event");

    psc_bypass_a: assert property (
        bypass && !wrCount |=> $stable(psc_ff))
        else $error("prescaler moved while bypassed");

    psc_ratio_a: assert property (
        !bypass && !css && incEn |-> (psc_ff & pscMask) == pscMask)
        else $error("prescaled increment before ratio reached");

    pin_sample_a: assert property (
        css && incEn |-> sampleEn)
        else $error("pin count applied off a sample point");

    pend_drop_a: assert property (
        css && pend_ff && sampleEn && !pscOut |=> !pend_ff)
        else $error("pending pin event not consumed");

    sleep_psc_a: assert property (
        sleepMode && !wrCount |=> $stable(psc_ff))
        else $error("prescaler moved while asleep");

    sleep_wrap_a: assert property (
        sleepMode |-> !ovf)
        else $error("overflow while asleep");

    gate_quiet_a: assert property (
        !ovf |=> !overflowEvent)
        else $error("overflow event without a wrap");

    hold_step_a: assert property (
        q4En && hold_ff != 2'h0 && !wrCount |=> hold_ff == $past(hold_ff) - 2'h1)
        else $error("hold-off did not count down");

    irq_drop_a: assert property (
        !(flag_ff && ien_ff) |=> !irq)
        else $error("interrupt high without enabled flag");
endmodule : ebtc_timer

// >>> dv/ebtc_pin_src.sv
`timescale 1ns/100ps
// ----------------------------------------
// external count source
// ----------------------------------------
module ebtc_pin_src (
    input  wire logic mclk,
    output logic      pin
);
    logic [1:0] divCnt_ff = 2'h0;
    initial pin = 1'b0;
    // three clocks per level, so each edge is long enough to be seen
    always @(posedge mclk) begin
        if (divCnt_ff == 2'h2) begin
            divCnt_ff <= 2'h0;
            pin       <= ~pin;
        end else begin
            divCnt_ff <= divCnt_ff + 2'h1;
        end
    end
endmodule : ebtc_pin_src

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import ebtc_pkg::*;
    typedef struct {logic [7:0] ctrl; int win; int delta;} ebtc_row_t;
    // ----------------------------------------
    // stimulus and checks
    // ----------------------------------------
    logic              mclk, reset, read, write, waitrequest;
    logic              externalCountPin, sleepMode, overflowEvent, irq;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata, readdata, rd;
    logic [3:0]        byteenable;
    int                err_count = 0;
    int                n_tests = 0;
    int                ovCount = 0;
    int                ov0;
    logic [7:0]        c0;
    logic [4:0]        rstAddr[4] = '{OFS_COUNT, OFS_CTRL, OFS_STATUS, OFS_ENABLE};
    logic [7:0]        rstVal[4] = '{8'h00, 8'h3f, 8'h00, 8'h00};
    // window lengths are whole periods of every clock in play
    ebtc_row_t         rows[5] = '{'{8'h08, 400, 100}, '{8'h00, 400, 50},
        '{8'h28, 600, 100}, '{8'h38, 600, 100}, '{8'h20, 600, 50}};

    ebtc_timer dut_u (.mclk(mclk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .externalCountPin(externalCountPin), .sleepMode(sleepMode),
        .overflowEvent(overflowEvent), .irq(irq));
    ebtc_pin_src src_u (.mclk(mclk), .pin(externalCountPin));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (overflowEvent === 1'b1) ovCount++;

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge mclk);
        read       <= ~w;
        write      <= w;
        address    <= a;
        writedata  <= {24'h0, d};
        byteenable <= be;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task rchk(input string nm, input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'hf);
        chk(nm, rd, {24'h0, exp});
    endtask : rchk

    task measure(input int win, input int delta);
        bus(1'b0, OFS_COUNT, 8'h00, 4'hf);
        c0 = rd[7:0];
        repeat (win - 3) @(posedge mclk);
        bus(1'b0, OFS_COUNT, 8'h00, 4'hf);
        chk("delta", {24'h0, rd[7:0] - c0}, 32'(delta));
    endtask : measure

    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'hf;
        sleepMode = 1'b0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            bus(1'b1, OFS_CTRL, rows[i].ctrl, 4'h1);
            measure(rows[i].win, rows[i].delta);
        end
        for (int r = 0; r < 8; r++) begin
            bus(1'b1, OFS_CTRL, 8'(r), 4'h1);
            measure(8 << (r + 1), 2);
        end
        bus(1'b1, OFS_COUNT, 8'h00, 4'h1);
        repeat (900) @(posedge mclk);
        rchk("count", OFS_COUNT, 8'h00);
        repeat (200) @(posedge mclk);
        rchk("count", OFS_COUNT, 8'h01);
        bus(1'b1, OFS_CTRL, 8'h08, 4'h1);
        bus(1'b1, OFS_COUNT, 8'h00, 4'h1);
        bus(1'b1, OFS_CLEAR, 8'h01, 4'h1);
        rchk("status", OFS_STATUS, 8'h00);
        bus(1'b1, OFS_ENABLE, 8'h01, 4'h1);
        ov0 = ovCount;
        bus(1'b1, OFS_COUNT, 8'hfd, 4'h1);
        rchk("count", OFS_COUNT, 8'hfd);
        for (int n = 0; n < 60 && irq !== 1'b1; n++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h1);
        chk("event", 32'(ovCount - ov0), 32'h1);
        bus(1'b1, OFS_ENABLE, 8'h00, 4'h1);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h0);
        rchk("status", OFS_STATUS, 8'h01);
        rchk("clear", OFS_CLEAR, 8'h00);
        bus(1'b1, OFS_CLEAR, 8'h01, 4'h1);
        rchk("status", OFS_STATUS, 8'h00);
        repeat (1100) @(posedge mclk);
        rchk("status", OFS_STATUS, 8'h01);
        chk("irq", {31'h0, irq}, 32'h0);
        sleepMode <= 1'b1;
        bus(1'b1, OFS_COUNT, 8'ha5, 4'h1);
        bus(1'b1, OFS_COUNT, 8'h55, 4'h0);
        bus(1'b1, 5'h14, 8'h55, 4'h1);
        repeat (100) @(posedge mclk);
        rchk("count", OFS_COUNT, 8'ha5);
        rchk("unmapped", 5'h14, 8'h00);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        foreach (rstAddr[i]) rchk("reset", rstAddr[i], rstVal[i]);
        report_and_stop();
    end
endmodule : testbench
